/* hdl/dtc_consts.vh */
// Purpose: constants for the dual timer/counter
// Assumes: 100 MHz mclk used as the oscillator clock
// Notes:   register addresses are index values on the plain register port
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// ****************************************
// register map
// ****************************************
`define DTC_ADDR_W         3
`define DTC_ADDR_MODE      3'h0
`define DTC_ADDR_CTRL      3'h1
`define DTC_ADDR_A_LOW     3'h2
`define DTC_ADDR_A_HIGH    3'h3
`define DTC_ADDR_B_LOW     3'h4
`define DTC_ADDR_B_HIGH    3'h5
`define DTC_ADDR_ACK       3'h6

// ****************************************
// field positions
// ****************************************
`define DTC_MOD_B_GATE     7
`define DTC_MOD_B_CT       6
`define DTC_MOD_A_GATE     3
`define DTC_MOD_A_CT       2
`define DTC_MOD_B_MODE_HI  5
`define DTC_MOD_A_MODE_HI  1
`define DTC_CON_B_OVF      7
`define DTC_CON_B_RUN      6
`define DTC_CON_A_OVF      5
`define DTC_CON_A_RUN      4
`define DTC_CON_IRQB_FLAG  3
`define DTC_CON_IRQB_TYPE  2
`define DTC_CON_IRQA_FLAG  1
`define DTC_CON_IRQA_TYPE  0
`define DTC_ACK_A_OVF      0
`define DTC_ACK_B_OVF      1
`define DTC_ACK_IRQA       2
`define DTC_ACK_IRQB       3

// ****************************************
// modes, reset values, timing
// ****************************************
`define DTC_MODE_13        2'h0
`define DTC_MODE_16        2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3
`define DTC_RST_BYTE       8'h00
`define DTC_OSC_PER_CYCLE  12
`define DTC_STATE_W        4
`define DTC_STATE_LAST     4'hb
`define DTC_STATE_SAMPLE   4'h9
`define DTC_STATE_UPDATE   4'h4
`define DTC_PRESCALE_MASK  8'h1f
`define DTC_BYTE_ONES      8'hff
`define DTC_ONE_BYTE       8'h01

`endif

/* hdl/dtc_edge_sampler.v */
// Purpose: samples a count pin once per machine cycle and flags falling edges
// Assumes: pin synchronous to mclk
// Notes:   edge pulse lasts one mclk, raised at the sample phase
`timescale 1ns/1ps
`include "dtc_consts.vh"

module dtc_edge_sampler (
  input  wire mclk,
  input  wire arst_n,
  input  wire sample_stb,
  input  wire pin,
  output reg  fall_reg
);

  reg cur_reg;

  // two samples in consecutive machine cycles: high then low means one event
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // sample starts low so a pin idling low cannot fake an edge
      cur_reg  <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      fall_reg <= 1'b0;
      if (sample_stb) begin
        cur_reg  <= pin;                     // [R2]
        fall_reg <= cur_reg & ~pin;          // [R2] [R4]
      end
    end
  end

endmodule // dtc_edge_sampler

/* hdl/dtc_timer.v */
// Purpose: two 8/13/16-bit timer/counters with mode and control registers
// Assumes: mclk is the oscillator clock; pins synchronous to mclk
// Notes:   vector acknowledge is a write-one pulse register standing in for the cpu
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dtc_consts.vh"

// Operation
// R1: timer mode counts once per twelve clocks
// R2: count pin sampled once per machine cycle
// R3: counted edge shows at next cycle update
// R4: edge needs two samples, max rate 1/24
// R5: source holds each level one machine cycle
// R6: counter-select picks machine cycles or pin
// R7: counts only if run and gate allows
// R8: mode 0 low byte is 5-bit prescaler
// R9: 13-bit count is high plus low five
// R10: mode 1 cascades both bytes, 16 bits
// R11: mode 2 low byte reloads from high
// R12: split: a high byte uses b controls
// R13: timer b in split mode holds still
// R14: rollover to zero sets overflow flag
// R15: setting run keeps the count registers
// R16: both timers share mode behaviour; timer b has no split mode, mode 3 holds it
// R17: gate bits at mode bits 7 and 3
// R18: overflow flags at 7 and 5, ack clears
// R19: run bits at 6 and 4 writable
// R20: edge flags at 3 and 1, ack clears
// R21: type bits at 2 and 0, edge/level
// R22: split high byte uses b run/overflow
// R23: mode codes 00 13,01 16,10 reload,11 split
module dtc_timer (
  input  wire                   mclk,
  input  wire                   arst_n,
  input  wire [`DTC_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr_stb,
  input  wire                   rd_stb,
  output reg  [7:0]             rdata_reg,
  input  wire                   timer_a_count_pin,
  input  wire                   timer_b_count_pin,
  input  wire                   ext_irq_a_pin,
  input  wire                   ext_irq_b_pin,
  output reg                    timer_a_overflow_reg,
  output reg                    timer_b_overflow_reg,
  output reg                    ext_irq_a_req_reg,
  output reg                    ext_irq_b_req_reg
);

  // ****************************************
  // storage
  // ****************************************
  reg  [7:0]               timer_mode_control_reg;
  reg                      timer_a_run_reg;
  reg                      timer_b_run_reg;
  reg                      ext_irq_a_type_reg;
  reg                      ext_irq_b_type_reg;
  reg                      ext_irq_a_edge_flag_reg;
  reg                      ext_irq_b_edge_flag_reg;
  reg                      irq_a_prev_reg;
  reg                      irq_b_prev_reg;
  reg  [7:0]               timer_a_low_count_reg;
  reg  [7:0]               timer_a_high_count_reg;
  reg  [7:0]               timer_b_low_count_reg;
  reg  [7:0]               timer_b_high_count_reg;
  reg  [`DTC_STATE_W-1:0]  state_reg;
  reg                      pend_a_reg;
  reg                      pend_b_reg;
  wire                     fall_a;
  wire                     fall_b;

  // ****************************************
  // functions
  // ****************************************
  // 8-bit increment with carry out
  function [8:0] inc8;
    input [7:0] v;
    begin
      inc8 = {1'b0, v} + {1'b0, `DTC_ONE_BYTE};
    end
  endfunction

  // mode 0 prescaler wrap: the five low bits are all ones
  function wrap13;
    input [7:0] v;
    begin
      wrap13 = ((v & `DTC_PRESCALE_MASK) == `DTC_PRESCALE_MASK);
    end
  endfunction

  // ****************************************
  // machine-cycle state counter
  // ****************************************
  wire last_state   = (state_reg == `DTC_STATE_LAST);
  wire sample_state = (state_reg == `DTC_STATE_SAMPLE);
  wire update_state = (state_reg == `DTC_STATE_UPDATE);

  // twelve oscillator periods per machine cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= {`DTC_STATE_W{1'b0}};
    end else if (last_state) begin
      state_reg <= {`DTC_STATE_W{1'b0}};          // [R1]
    end else begin
      state_reg <= state_reg + 1'b1;
    end
  end

  dtc_edge_sampler u_samp_a (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .sample_stb (sample_state),
    .pin        (timer_a_count_pin),
    .fall_reg   (fall_a)
  );

  dtc_edge_sampler u_samp_b (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .sample_stb (sample_state),
    .pin        (timer_b_count_pin),
    .fall_reg   (fall_b)
  );

  // ****************************************
  // count enables
  // ****************************************
  wire [1:0] mode_a  = timer_mode_control_reg[`DTC_MOD_A_MODE_HI -: 2];
  wire [1:0] mode_b  = timer_mode_control_reg[`DTC_MOD_B_MODE_HI -: 2];
  wire       split_a = (mode_a == `DTC_MODE_SPLIT);   // [R23]
  wire       split_b = (mode_b == `DTC_MODE_SPLIT);

  // gate pin only matters with the gate bit set
  wire gate_ok_a = ~timer_mode_control_reg[`DTC_MOD_A_GATE] | ext_irq_a_pin;  // [R17]
  wire gate_ok_b = ~timer_mode_control_reg[`DTC_MOD_B_GATE] | ext_irq_b_pin;
  wire en_a = timer_a_run_reg & gate_ok_a;                              // [R7]
  wire en_b = timer_b_run_reg & gate_ok_b & ~split_b;                   // [R7] [R13]

  // pin edges are latched and applied at the update phase of the next cycle
  wire ev_a = timer_mode_control_reg[`DTC_MOD_A_CT] ? pend_a_reg : last_state;  // [R6]
  wire ev_b = timer_mode_control_reg[`DTC_MOD_B_CT] ? pend_b_reg : last_state;  // [R6]
  wire tick_a = en_a & (timer_mode_control_reg[`DTC_MOD_A_CT] ? update_state : last_state);
  wire tick_b = en_b & (timer_mode_control_reg[`DTC_MOD_B_CT] ? update_state : last_state);
  wire cnt_a  = tick_a & ev_a;
  wire cnt_b  = tick_b & ev_b;
  // split high byte is timer-only, run by b's run bit
  wire cnt_ah = split_a & timer_b_run_reg & last_state;                 // [R12] [R22]

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else begin
      if (fall_a) pend_a_reg <= 1'b1;
      else if (update_state) pend_a_reg <= 1'b0;                        // [R3]
      if (fall_b) pend_b_reg <= 1'b1;
      else if (update_state) pend_b_reg <= 1'b0;                        // [R3]
    end
  end

  // ****************************************
  // counters, shared by both timers
  // ****************************************
  reg [7:0] a_low_next;
  reg [7:0] a_high_next;
  reg [7:0] b_low_next;
  reg [7:0] b_high_next;
  reg       ovf_a_ev;
  reg       ovf_b_ev;
  reg [8:0] lo_a;
  reg [8:0] hi_a;
  reg [8:0] lo_b;
  reg [8:0] hi_b;
  reg [8:0] hi_split;

  always @* begin
    a_low_next  = timer_a_low_count_reg;
    a_high_next = timer_a_high_count_reg;
    b_low_next  = timer_b_low_count_reg;
    b_high_next = timer_b_high_count_reg;
    ovf_a_ev    = 1'b0;
    ovf_b_ev    = 1'b0;
    lo_a = inc8(timer_a_low_count_reg);
    hi_a = inc8(timer_a_high_count_reg);
    lo_b = inc8(timer_b_low_count_reg);
    hi_b = inc8(timer_b_high_count_reg);
    hi_split = inc8(timer_a_high_count_reg);
    if (cnt_a) begin                                                    // [R16]
      case (mode_a)
        `DTC_MODE_13: begin                                            // [R8] [R9]
          a_low_next = lo_a[7:0] & `DTC_PRESCALE_MASK;
          if (wrap13(timer_a_low_count_reg)) begin
            a_high_next = hi_a[7:0];
            ovf_a_ev    = hi_a[8];                                      // [R14]
          end
        end
        `DTC_MODE_16: begin                                            // [R10]
          a_low_next = lo_a[7:0];
          if (lo_a[8]) begin
            a_high_next = hi_a[7:0];
            ovf_a_ev    = hi_a[8];                                      // [R14]
          end
        end
        `DTC_MODE_RELOAD: begin                                        // [R11]
          a_low_next = lo_a[8] ? timer_a_high_count_reg : lo_a[7:0];
          ovf_a_ev   = lo_a[8];
        end
        default: begin                                                 // [R12]
          a_low_next = lo_a[7:0];
          ovf_a_ev   = lo_a[8];
        end
      endcase
    end
    if (cnt_ah) begin
      a_high_next = hi_split[7:0];
      ovf_b_ev    = hi_split[8];                                        // [R22]
    end
    if (cnt_b) begin                                                    // [R16]
      case (mode_b)
        `DTC_MODE_13: begin                                            // [R8]
          b_low_next = lo_b[7:0] & `DTC_PRESCALE_MASK;
          if (wrap13(timer_b_low_count_reg)) begin
            b_high_next = hi_b[7:0];
            ovf_b_ev    = ovf_b_ev | hi_b[8];
          end
        end
        `DTC_MODE_16: begin                                            // [R10]
          b_low_next = lo_b[7:0];
          if (lo_b[8]) begin
            b_high_next = hi_b[7:0];
            ovf_b_ev    = ovf_b_ev | hi_b[8];
          end
        end
        default: begin                                                 // [R11]
          b_low_next = lo_b[8] ? timer_b_high_count_reg : lo_b[7:0];
          ovf_b_ev   = ovf_b_ev | lo_b[8];
        end
      endcase
    end
  end

  // ****************************************
  // external interrupt detection
  // ****************************************
  wire irq_a_hit = ext_irq_a_type_reg ? (irq_a_prev_reg & ~ext_irq_a_pin) : ~ext_irq_a_pin;
  wire irq_b_hit = ext_irq_b_type_reg ? (irq_b_prev_reg & ~ext_irq_b_pin) : ~ext_irq_b_pin;

  // ****************************************
  // register port
  // ****************************************
  wire wr_mode = wr_stb & (addr == `DTC_ADDR_MODE);
  wire wr_ctrl = wr_stb & (addr == `DTC_ADDR_CTRL);
  wire wr_ack  = wr_stb & (addr == `DTC_ADDR_ACK);
  wire ack_a_ovf = wr_ack & wdata[`DTC_ACK_A_OVF];
  wire ack_b_ovf = wr_ack & wdata[`DTC_ACK_B_OVF];
  wire ack_irqa  = wr_ack & wdata[`DTC_ACK_IRQA];
  wire ack_irqb  = wr_ack & wdata[`DTC_ACK_IRQB];
  // count byte writes; the ack address is write-only and reads as zero
  wire wr_a_low  = wr_stb & (addr == `DTC_ADDR_A_LOW);
  wire wr_a_high = wr_stb & (addr == `DTC_ADDR_A_HIGH);
  wire wr_b_low  = wr_stb & (addr == `DTC_ADDR_B_LOW);
  wire wr_b_high = wr_stb & (addr == `DTC_ADDR_B_HIGH);

  // hardware set wins over any clear in the same cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_mode_control_reg  <= `DTC_RST_BYTE;
      timer_a_run_reg         <= 1'b0;
      timer_b_run_reg         <= 1'b0;
      ext_irq_a_type_reg      <= 1'b0;
      ext_irq_b_type_reg      <= 1'b0;
      ext_irq_a_edge_flag_reg <= 1'b0;
      ext_irq_b_edge_flag_reg <= 1'b0;
      irq_a_prev_reg          <= 1'b1;
      irq_b_prev_reg          <= 1'b1;
      timer_a_overflow_reg    <= 1'b0;
      timer_b_overflow_reg    <= 1'b0;
      ext_irq_a_req_reg       <= 1'b0;
      ext_irq_b_req_reg       <= 1'b0;
      timer_a_low_count_reg   <= `DTC_RST_BYTE;
      timer_a_high_count_reg  <= `DTC_RST_BYTE;
      timer_b_low_count_reg   <= `DTC_RST_BYTE;
      timer_b_high_count_reg  <= `DTC_RST_BYTE;
    end else begin
      irq_a_prev_reg <= ext_irq_a_pin;
      irq_b_prev_reg <= ext_irq_b_pin;
      if (wr_mode) timer_mode_control_reg <= wdata;                    // [R17] [R23]
      // counters keep their value when run is set
      if (wr_ctrl) begin
        timer_a_run_reg    <= wdata[`DTC_CON_A_RUN];                    // [R19] [R15]
        timer_b_run_reg    <= wdata[`DTC_CON_B_RUN];                    // [R19]
        ext_irq_a_type_reg <= wdata[`DTC_CON_IRQA_TYPE];                // [R21]
        ext_irq_b_type_reg <= wdata[`DTC_CON_IRQB_TYPE];                // [R21]
      end
      // software may also write the flags; an ack outranks that write
      if (ovf_a_ev) timer_a_overflow_reg <= 1'b1;                       // [R14] [R18]
      else if (ack_a_ovf) timer_a_overflow_reg <= 1'b0;                 // [R18]
      else if (wr_ctrl) timer_a_overflow_reg <= wdata[`DTC_CON_A_OVF];
      if (ovf_b_ev) timer_b_overflow_reg <= 1'b1;                       // [R18] [R22]
      else if (ack_b_ovf) timer_b_overflow_reg <= 1'b0;
      else if (wr_ctrl) timer_b_overflow_reg <= wdata[`DTC_CON_B_OVF];
      if (irq_a_hit) ext_irq_a_edge_flag_reg <= 1'b1;                   // [R20]
      else if (ack_irqa) ext_irq_a_edge_flag_reg <= 1'b0;               // [R20]
      else if (wr_ctrl) ext_irq_a_edge_flag_reg <= wdata[`DTC_CON_IRQA_FLAG];
      if (irq_b_hit) ext_irq_b_edge_flag_reg <= 1'b1;                   // [R20]
      else if (ack_irqb) ext_irq_b_edge_flag_reg <= 1'b0;
      else if (wr_ctrl) ext_irq_b_edge_flag_reg <= wdata[`DTC_CON_IRQB_FLAG];
      ext_irq_a_req_reg <= irq_a_hit | (ext_irq_a_edge_flag_reg & ~ack_irqa);
      ext_irq_b_req_reg <= irq_b_hit | (ext_irq_b_edge_flag_reg & ~ack_irqb);
      // a software write to a count byte takes priority over counting
      if (wr_a_low) timer_a_low_count_reg <= wdata;
      else timer_a_low_count_reg <= a_low_next;
      if (wr_a_high) timer_a_high_count_reg <= wdata;
      else timer_a_high_count_reg <= a_high_next;
      if (wr_b_low) timer_b_low_count_reg <= wdata;
      else timer_b_low_count_reg <= b_low_next;
      if (wr_b_high) timer_b_high_count_reg <= wdata;
      else timer_b_high_count_reg <= b_high_next;
    end
  end

  // read data valid the cycle after the strobe only
  // idle cycles return zero so a stale byte never looks fresh
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= `DTC_RST_BYTE;
    end else if (!rd_stb) begin
      rdata_reg <= `DTC_RST_BYTE;
    end else if (addr == `DTC_ADDR_MODE) begin
      rdata_reg <= timer_mode_control_reg;
    end else if (addr == `DTC_ADDR_CTRL) begin
      rdata_reg <= {timer_b_overflow_reg, timer_b_run_reg, timer_a_overflow_reg,
                    timer_a_run_reg, ext_irq_b_edge_flag_reg, ext_irq_b_type_reg,
                    ext_irq_a_edge_flag_reg, ext_irq_a_type_reg};
    end else if (addr == `DTC_ADDR_A_LOW) begin
      rdata_reg <= timer_a_low_count_reg;
    end else if (addr == `DTC_ADDR_A_HIGH) begin
      rdata_reg <= timer_a_high_count_reg;
    end else if (addr == `DTC_ADDR_B_LOW) begin
      rdata_reg <= timer_b_low_count_reg;
    end else if (addr == `DTC_ADDR_B_HIGH) begin
      rdata_reg <= timer_b_high_count_reg;
    end else begin
      rdata_reg <= `DTC_RST_BYTE;
    end
  end

endmodule // dtc_timer

/* dv/dtc_timer_properties.sv */
// Purpose: port-level properties of the dual timer/counter
// Assumes: only the top module's ports are visible
// Notes:   mode shadow and the control run and type bits are exact, those bits are software-only
`timescale 1ns/1ps
`include "dtc_consts.vh"

module dtc_timer_properties (
  input wire                   mclk,
  input wire                   arst_n,
  input wire [`DTC_ADDR_W-1:0] addr,
  input wire [7:0]             wdata,
  input wire                   wr_stb,
  input wire                   rd_stb,
  input wire [7:0]             rdata_reg,
  input wire                   ext_irq_a_pin,
  input wire                   ext_irq_b_pin,
  input wire                   timer_a_overflow_reg,
  input wire                   timer_b_overflow_reg,
  input wire                   ext_irq_a_req_reg,
  input wire                   ext_irq_b_req_reg
);
  reg [7:0] mode_sh_reg;
  reg [7:0] ctl_sh_reg;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sh_reg <= 8'h00;
      ctl_sh_reg  <= 8'h00;
    end else if (wr_stb && addr == `DTC_ADDR_MODE) begin
      mode_sh_reg <= wdata;
    end else if (wr_stb && addr == `DTC_ADDR_CTRL) begin
      ctl_sh_reg <= wdata;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ********
  // properties
  // ********
  sequence s_mode_wr;
    wr_stb && addr == `DTC_ADDR_MODE;
  endsequence
  sequence s_mode_rd;
    rd_stb && addr == `DTC_ADDR_MODE;
  endsequence

  a_mode_readback: assert property (
    s_mode_wr ##1 s_mode_rd |=> rdata_reg == $past(wdata, 2)) else $error("mode readback");
  a_ovf_a_bit: assert property (
    rd_stb && addr == `DTC_ADDR_CTRL |=> rdata_reg[5] == $past(timer_a_overflow_reg))
    else $error("ctrl bit 5 differs from flag a");
  a_ovf_b_bit: assert property (
    rd_stb && addr == `DTC_ADDR_CTRL |=> rdata_reg[7] == $past(timer_b_overflow_reg))
    else $error("ctrl bit 7 differs from flag b");
  a_level_irq_a: assert property (
    !ctl_sh_reg[0] && !ext_irq_a_pin |=> ext_irq_a_req_reg) else $error("level a missed");
  a_level_irq_b: assert property (
    !ctl_sh_reg[2] && !ext_irq_b_pin |=> ext_irq_b_req_reg) else $error("level b missed");
  a_edge_irq_a: assert property (
    ctl_sh_reg[0] && $fell(ext_irq_a_pin) |=> ext_irq_a_req_reg) else $error("edge a missed");
  // a pending pin edge could still land after a mode change; the bench avoids that
  a_split_b_hold: assert property (
    $rose(timer_b_overflow_reg) |-> $past(mode_sh_reg[5:4] != `DTC_MODE_SPLIT ||
    mode_sh_reg[1:0] == `DTC_MODE_SPLIT || (wr_stb && addr == `DTC_ADDR_CTRL)))
    else $error("held timer b overflowed");
  a_ovf_needs_run: assert property (
    $rose(timer_a_overflow_reg) |-> $past(ctl_sh_reg[4] || (wr_stb && addr == `DTC_ADDR_CTRL)))
    else $error("timer a overflowed while stopped");
endmodule // dtc_timer_properties

bind dtc_timer dtc_timer_properties dtc_timer_properties_i (
  .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_reg(rdata_reg), .ext_irq_a_pin(ext_irq_a_pin),
  .ext_irq_b_pin(ext_irq_b_pin), .timer_a_overflow_reg(timer_a_overflow_reg),
  .timer_b_overflow_reg(timer_b_overflow_reg), .ext_irq_a_req_reg(ext_irq_a_req_reg),
  .ext_irq_b_req_reg(ext_irq_b_req_reg));

/* dv/dtc_pin_source.sv */
// Purpose: external event source on the two count pins
// Assumes: one request at a time, hold_cyc taken at each request
// Notes:   idle level is the pull-up high
`timescale 1ns/1ps

module dtc_pin_source (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire [1:0] fall_req,
  input  wire [4:0] hold_cyc,
  output reg        timer_a_count_pin,
  output reg        timer_b_count_pin
);
  reg [5:0] left_reg;
  reg [4:0] half_reg;
  reg [1:0] sel_reg;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      left_reg <= 6'h00;
      half_reg <= 5'h00;
      sel_reg  <= 2'h0;
    end else if (left_reg != 6'h00) begin
      left_reg <= left_reg - 6'h01;
    end else if (fall_req != 2'h0) begin
      sel_reg  <= fall_req;
      half_reg <= hold_cyc;
      left_reg <= {hold_cyc, 1'b0};
    end
  end

  // low for one hold period then high for another; shorter levels would lose edges
  always @* begin
    timer_a_count_pin = !(sel_reg[0] && left_reg > {1'b0, half_reg});
    timer_b_count_pin = !(sel_reg[1] && left_reg > {1'b0, half_reg});
  end
endmodule // dtc_pin_source

/* dv/dtc_timer_tb.sv */
// Purpose: self-checking bench for the dual timer/counter
// Assumes: read data stand one cycle after the strobe
// Notes:   reads queue their expectation, a negedge monitor compares
`timescale 1ns/1ps
`include "dtc_consts.vh"

module dtc_timer_tb;
  reg [`DTC_ADDR_W-1:0] addr;
  reg [7:0]  wdata;
  reg        mclk, arst_n, wr_stb, rd_stb, rd_d, ext_irq_a_pin, ext_irq_b_pin;
  reg [1:0]  fall_req;
  reg [4:0]  hold_cyc;
  reg [31:0] seed;
  reg [63:0] case_tbl [0:8];
  reg [63:0] c;
  reg [7:0]  exp_q [$];
  wire [7:0] rdata_reg;
  wire       timer_a_count_pin, timer_b_count_pin, timer_a_overflow_reg;
  wire       timer_b_overflow_reg, ext_irq_a_req_reg, ext_irq_b_req_reg;
  integer    bad_count, cmp_count, cyc, i, n;

  dtc_timer dtc_timer_i (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_reg(rdata_reg),
    .timer_a_count_pin(timer_a_count_pin), .timer_b_count_pin(timer_b_count_pin),
    .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin),
    .timer_a_overflow_reg(timer_a_overflow_reg), .timer_b_overflow_reg(timer_b_overflow_reg),
    .ext_irq_a_req_reg(ext_irq_a_req_reg), .ext_irq_b_req_reg(ext_irq_b_req_reg));
  dtc_pin_source dtc_pin_source_i (.mclk(mclk), .arst_n(arst_n), .fall_req(fall_req),
    .hold_cyc(hold_cyc), .timer_a_count_pin(timer_a_count_pin),
    .timer_b_count_pin(timer_b_count_pin));

  // ********
  // helpers
  // ********
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task check(input [7:0] seen, input [7:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  // strobes stay up between back-to-back calls; idle drops them
  task bus(input w, input [2:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr_stb <= w;
      rd_stb <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge mclk);
    end
  endtask
  task idle;
    begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      bus(1'b1, a, d);
      idle;
    end
  endtask
  task rd(input [2:0] a, input [7:0] e);
    begin
      bus(1'b0, a, e);
      idle;
    end
  endtask
  task wait_flag(input b, input integer lim, output integer k);
    integer j;
    begin
      k = 0;
      for (j = 1; j <= lim && k == 0; j = j + 1) begin
        @(negedge mclk);
        if ((b ? timer_b_overflow_reg : timer_a_overflow_reg) === 1'b1) k = j;
      end
      @(posedge mclk);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rd_d <= rd_stb;
    cyc = cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  always @(negedge mclk) if (rd_d) check(rdata_reg, exp_q.pop_front());

  // ********
  // scenarios
  // ********
  initial begin
    {arst_n, addr, wdata, wr_stb, rd_stb, rd_d, fall_req} = 0;
    {ext_irq_a_pin, ext_irq_b_pin, hold_cyc} = {2'b11, 5'd12};
    {seed, bad_count, cmp_count, cyc} = {32'h6, 32'd0, 32'd0, 32'd0};
    // mode, low, high, base, run, sel(b0 flag b, b1 none), low after, high after
    case_tbl[0] = 64'h01_fe_ff_02_10_00_00_00;
    case_tbl[1] = 64'h00_fe_ff_02_10_00_00_00;
    case_tbl[2] = 64'h02_fe_80_02_10_00_80_80;
    case_tbl[3] = 64'h03_fe_00_02_10_00_00_00;
    case_tbl[4] = 64'h03_00_fe_02_40_01_00_00;
    case_tbl[5] = 64'h10_fe_ff_04_40_01_00_00;
    case_tbl[6] = 64'h30_fe_ff_04_40_03_fe_ff;
    case_tbl[7] = 64'h20_fe_80_04_40_01_80_80;
    case_tbl[8] = 64'h00_fe_ff_04_40_01_00_00;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 8; i = i + 1) rd(i[2:0], 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      bus(1'b1, `DTC_ADDR_MODE, seed[7:0]);
      bus(1'b0, `DTC_ADDR_MODE, seed[7:0]);
      idle;
    end
    for (i = 0; i < 9; i = i + 1) begin
      c = case_tbl[i];
      wr(`DTC_ADDR_CTRL, 8'h00);
      wr(`DTC_ADDR_MODE, c[63:56]);
      wr(c[34:32], c[55:48]);
      wr(c[34:32] + 3'h1, c[47:40]);
      wr(`DTC_ADDR_CTRL, c[31:24]);
      wait_flag(c[16], 30, n);
      check({7'h00, c[17] ? n == 0 : (n >= 12 && n <= 25)}, 8'h01);
      rd(`DTC_ADDR_CTRL, c[17] ? c[31:24] : c[31:24] | (c[31:24] << 1));
      wr(`DTC_ADDR_ACK, 8'h0f);
      check({7'h00, c[16] ? timer_b_overflow_reg : timer_a_overflow_reg}, 8'h00);
      wr(`DTC_ADDR_CTRL, 8'h00);
      rd(c[34:32], c[15:8]);
      rd(c[34:32] + 3'h1, c[7:0]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      seed = xs(seed);
      hold_cyc <= 5'd12 + {2'b00, seed[2:0]};
      wr(`DTC_ADDR_CTRL, 8'h00);
      wr(`DTC_ADDR_MODE, i ? 8'h50 : 8'h05);
      wr(i ? `DTC_ADDR_B_LOW : `DTC_ADDR_A_LOW, 8'hff);
      wr(i ? `DTC_ADDR_B_HIGH : `DTC_ADDR_A_HIGH, 8'hff);
      wr(`DTC_ADDR_CTRL, i ? 8'h40 : 8'h10);
      wait_flag(i[0], 40, n);
      check({7'h00, n == 0}, 8'h01);
      fall_req <= i ? 2'h2 : 2'h1;
      @(posedge mclk);
      fall_req <= 2'h0;
      wait_flag(i[0], 40, n);
      check({7'h00, n >= 6 && n <= 24}, 8'h01);
      wr(`DTC_ADDR_ACK, 8'h0f);
    end
    wr(`DTC_ADDR_CTRL, 8'h00);
    wr(`DTC_ADDR_MODE, 8'h09);
    wr(`DTC_ADDR_A_LOW, 8'hfe);
    wr(`DTC_ADDR_A_HIGH, 8'hff);
    ext_irq_a_pin <= 1'b0;
    ext_irq_b_pin <= 1'b0;
    wr(`DTC_ADDR_CTRL, 8'h10);
    wait_flag(1'b0, 40, n);
    check({7'h00, n == 0}, 8'h01);
    rd(`DTC_ADDR_CTRL, 8'h1a);
    check({7'h00, ext_irq_b_req_reg}, 8'h01);
    ext_irq_a_pin <= 1'b1;
    ext_irq_b_pin <= 1'b1;
    wait_flag(1'b0, 30, n);
    check({7'h00, n >= 12 && n <= 26}, 8'h01);
    wr(`DTC_ADDR_ACK, 8'h0f);
    wr(`DTC_ADDR_CTRL, 8'h05);
    ext_irq_a_pin <= 1'b0;
    @(posedge mclk);
    ext_irq_a_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    check({7'h00, ext_irq_a_req_reg}, 8'h01);
    rd(`DTC_ADDR_CTRL, 8'h07);
    wr(`DTC_ADDR_ACK, 8'h04);
    @(negedge mclk);
    check({7'h00, ext_irq_a_req_reg}, 8'h00);
    @(posedge mclk);
    tally_and_finish;
  end
endmodule // dtc_timer_tb
